// ---- core/srg_status_groups.sv ----
`timescale 1ns/1ps
`include "srg_cfg.svh"
// Behaviour
// [R01] Operation, fault, per-phase groups: condition, enable, event
// [R02] Operation bit 0 on adjustment run done
// [R03] Operation bit 3 on output change done
// [R04] Operation bit 4 on reading cycle done
// [R05] Event registers read-only, latch until cleared
// [R06] Operation event read returns then clears
// [R07] Condition registers read-only, live source state
// [R08] Run summary is OR of enabled events
// [R09] Enable masks read/write, select summary contributors
// [R10] Per-phase fault event and condition copies
// [R11] Per-phase fault enable mask, selected phase only
// [R12] Software selects phase before per-phase access
// [R13] Fault summary at status byte bit 3
// [R14] Fault event read returns then clears
// [R15] Fault low byte carries eight fault flags
// [R16] Masks reset zero; unused bits read zero
module srg_status_groups #(
   parameter int PHASES = 3,
   parameter int AW     = 2
) (
   input  wire logic              mclk,
   input  wire logic              resetn,
   input  wire logic              adjust_done,
   input  wire logic              output_change_complete,
   input  wire logic              reading_complete,
   input  wire logic [7:0]        fault_flags,
   input  wire logic [8*PHASES-1:0] phase_fault_flags,
   input  wire logic              cmd_valid,
   input  wire logic              cmd_write,
   input  wire srg_pkg::srg_sel_t cmd_sel,
   input  wire srg_pkg::srg_word_t cmd_wdata,
   output logic                   cmd_rvalid,
   output srg_pkg::srg_word_t     cmd_rdata,
   output logic                   run_summary,
   output logic                   fault_summary,
   output logic                   per_phase_summary,
   output logic [7:0]             status_byte
);
   import srg_pkg::*;

   // ************************************************************
   // Read sequencer states, one-hot
   // ************************************************************
   typedef enum logic [2:0] {
      SRG_IDLE = 3'b001,
      SRG_WAIT = 3'b010,
      SRG_DONE = 3'b100
   } srg_state_e;

   // ************************************************************
   // State and wiring of the three groups
   // ************************************************************
   srg_state_e    st_r;
   srg_state_e    st_nxt;
   srg_sel_t      sel_r;
   srg_sel_t      sel_nxt;
   srg_word_t     run_cond;                 // [R01]
   srg_word_t     run_evt_r;                // [R01]
   srg_word_t     run_evt_nxt;
   srg_word_t     run_mask_r;               // [R01]
   srg_word_t     run_mask_nxt;
   srg_word_t     flt_cond;                 // [R01]
   srg_word_t     flt_evt_r;                // [R01]
   srg_word_t     flt_evt_nxt;
   srg_word_t     flt_mask_r;               // [R01]
   srg_word_t     flt_mask_nxt;
   srg_word_t     ph_cond [PHASES];         // [R01] [R10]
   srg_word_t     ph_evt [PHASES];          // [R01] [R10]
   logic [AW-1:0] phase_r;
   logic [AW-1:0] phase_nxt;
   srg_word_t     rdata_r;
   srg_word_t     rdata_nxt;
   logic          idle;
   logic          rd_go;
   logic          wr_go;
   logic          run_hit;
   logic          flt_hit;

   // ************************************************************
   // Per-phase enable mask store
   // ************************************************************
   srg_mask_if #(.PHASES(PHASES), .AW(AW)) mbus ();

   srg_mask_mem #(.PHASES(PHASES), .AW(AW)) u_mask (
      .mclk   (mclk),
      .resetn (resetn),
      .mbus   (mbus)
   );

   // ************************************************************
   // Command decode
   // ************************************************************
   // Requests arriving while a read is in flight are dropped
   assign idle  = (st_r == SRG_IDLE);
   assign rd_go = cmd_valid && !cmd_write && idle;
   assign wr_go = cmd_valid && cmd_write && idle;

   // The mask store is always addressed by the selected phase
   assign mbus.wr_en   = wr_go && (cmd_sel == `SRG_SEL_PH_MASK); // [R11]
   assign mbus.wr_addr = phase_r;                              // [R11]
   assign mbus.wr_data = cmd_wdata;
   assign mbus.rd_addr = phase_r;                              // [R11]

   // ************************************************************
   // Live condition words
   // ************************************************************
   always_comb begin
      // Unused positions stay zero
      run_cond = `SRG_ZERO16;
      run_cond[`SRG_RUN_ADJUST_BIT] = adjust_done;            // [R02] [R07]
      run_cond[`SRG_RUN_CHANGE_BIT] = output_change_complete; // [R03] [R07]
      run_cond[`SRG_RUN_READ_BIT]   = reading_complete;       // [R04] [R07]
      flt_cond = {8'h00, fault_flags};                        // [R15] [R16]
   end

   // ************************************************************
   // Operation group: event latch and enable mask
   // ************************************************************
   always_comb begin
      // Set wins over read-clear: a live condition re-sets its bit
      run_evt_nxt = run_evt_r | (run_cond & `SRG_RUN_USED);  // [R05]
      if (rd_go && (cmd_sel == `SRG_SEL_RUN_EVENT)) begin
         run_evt_nxt = run_cond & `SRG_RUN_USED;             // [R06]
      end
      run_mask_nxt = run_mask_r;
      if (wr_go && (cmd_sel == `SRG_SEL_RUN_MASK)) begin
         run_mask_nxt = cmd_wdata & `SRG_RUN_USED;           // [R09] [R16]
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         run_evt_r  <= `SRG_ZERO16;
         run_mask_r <= `SRG_ZERO16;                          // [R16]
      end else begin
         run_evt_r  <= run_evt_nxt;
         run_mask_r <= run_mask_nxt;
      end
   end

   // ************************************************************
   // Fault group: event latch and enable mask
   // ************************************************************
   always_comb begin
      // Set wins over read-clear, as in the operation group
      flt_evt_nxt = flt_evt_r | flt_cond;                    // [R05]
      if (rd_go && (cmd_sel == `SRG_SEL_FLT_EVENT)) begin
         flt_evt_nxt = flt_cond;                             // [R14]
      end
      flt_mask_nxt = flt_mask_r;
      if (wr_go && (cmd_sel == `SRG_SEL_FLT_MASK)) begin
         flt_mask_nxt = cmd_wdata & `SRG_FLT_USED;           // [R09] [R16]
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         flt_evt_r  <= `SRG_ZERO16;
         flt_mask_r <= `SRG_ZERO16;                          // [R16]
      end else begin
         flt_evt_r  <= flt_evt_nxt;
         flt_mask_r <= flt_mask_nxt;
      end
   end

   // ************************************************************
   // Per-phase fault events, one latch per phase
   // ************************************************************
   genvar g;
   generate
      for (g = 0; g < PHASES; g++) begin : g_ph
         srg_word_t evt_r;
         srg_word_t evt_nxt;
         logic      clr;

         assign ph_cond[g] = {8'h00, phase_fault_flags[8*g +: 8]}; // [R10] [R07]
         // Only the selected phase clears on its event read
         assign clr = rd_go && (cmd_sel == `SRG_SEL_PH_EVENT)
                      && (int'(phase_r) == g);                     // [R10]

         always_comb begin
            // Set wins over read-clear
            evt_nxt = evt_r | ph_cond[g];                          // [R05] [R10]
            if (clr) begin
               evt_nxt = ph_cond[g];                               // [R14] [R10]
            end
         end

         always_ff @(posedge mclk or negedge resetn) begin
            if (!resetn) begin
               evt_r <= `SRG_ZERO16;
            end else begin
               evt_r <= evt_nxt;
            end
         end

         assign ph_evt[g]        = evt_r;
         assign mbus.ph_event[g] = evt_r;
      end
   endgenerate

   // ************************************************************
   // Phase select
   // ************************************************************
   always_comb begin
      phase_nxt = phase_r;
      // The whole word is compared, so aliases of a phase are ignored too
      if (wr_go && (cmd_sel == `SRG_SEL_PHASE)) begin
         if (int'(cmd_wdata) < PHASES) begin
            phase_nxt = cmd_wdata[AW-1:0];                   // [R10] [R11]
         end
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         phase_r <= '0;
      end else begin
         phase_r <= phase_nxt;
      end
   end

   // ************************************************************
   // Read sequencer: one cycle wait for the mask store read port
   // ************************************************************
   always_comb begin
      st_nxt  = st_r;
      sel_nxt = sel_r;
      // The answer stands one edge after the taking edge, for one cycle
      case (st_r)
         SRG_IDLE: begin
            if (rd_go) begin
               st_nxt  = SRG_WAIT;
               sel_nxt = cmd_sel;
            end
         end
         SRG_WAIT: begin
            st_nxt = SRG_DONE;
         end
         SRG_DONE: begin
            st_nxt = SRG_IDLE;
         end
         default: begin
            st_nxt = SRG_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         st_r  <= SRG_IDLE;
         sel_r <= `SRG_SEL_RUN_COND;
      end else begin
         st_r  <= st_nxt;
         sel_r <= sel_nxt;
      end
   end

   // ************************************************************
   // Read data
   // ************************************************************
   always_comb begin
      rdata_nxt = rdata_r;
      if (rd_go) begin
         // Value is that seen at the taking edge
         case (cmd_sel)
            `SRG_SEL_RUN_COND:  rdata_nxt = run_cond;                  // [R07]
            `SRG_SEL_RUN_EVENT: rdata_nxt = run_evt_r;                 // [R06]
            `SRG_SEL_RUN_MASK:  rdata_nxt = run_mask_r;                // [R09]
            `SRG_SEL_FLT_COND:  rdata_nxt = flt_cond;                  // [R07]
            `SRG_SEL_FLT_EVENT: rdata_nxt = flt_evt_r;                 // [R14]
            `SRG_SEL_FLT_MASK:  rdata_nxt = flt_mask_r;                // [R09]
            `SRG_SEL_PH_COND:   rdata_nxt = ph_cond[phase_r];          // [R10]
            `SRG_SEL_PH_EVENT:  rdata_nxt = ph_evt[phase_r];           // [R10]
            `SRG_SEL_PHASE:     rdata_nxt = {{(16-AW){1'b0}}, phase_r};
            default:            rdata_nxt = `SRG_ZERO16;               // [R16]
         endcase
      end else if ((st_r == SRG_WAIT) && (sel_r == `SRG_SEL_PH_MASK)) begin
         // Mask words arrive from the store one cycle later
         rdata_nxt = mbus.rd_data;                                     // [R11]
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rdata_r <= `SRG_ZERO16;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   // ************************************************************
   // Summaries and status byte
   // ************************************************************
   assign run_hit           = |(run_evt_r & run_mask_r);       // [R08] [R09]
   assign flt_hit           = |(flt_evt_r & flt_mask_r);       // [R13] [R09]
   assign run_summary       = run_hit;                         // [R08]
   assign per_phase_summary = |mbus.any_hit;                   // [R11]
   // Per-phase hits fold into the fault summary
   assign fault_summary     = flt_hit | per_phase_summary;     // [R13]
   assign cmd_rvalid        = (st_r == SRG_DONE);
   assign cmd_rdata         = rdata_r;

   always_comb begin
      status_byte = 8'h00;
      status_byte[`SRG_STB_FAULT_BIT] = fault_summary; // [R13]
      status_byte[`SRG_STB_RUN_BIT]   = run_summary;   // [R08]
   end
endmodule : srg_status_groups

// ---- core/srg_cfg.svh ----
`ifndef SRG_CFG_SVH
`define SRG_CFG_SVH
// Register selectors on the status command port
`define SRG_SEL_RUN_COND   4'h0
`define SRG_SEL_RUN_EVENT  4'h1
`define SRG_SEL_RUN_MASK   4'h2
`define SRG_SEL_FLT_COND   4'h3
`define SRG_SEL_FLT_EVENT  4'h4
`define SRG_SEL_FLT_MASK   4'h5
`define SRG_SEL_PH_COND    4'h6
`define SRG_SEL_PH_EVENT   4'h7
`define SRG_SEL_PH_MASK    4'h8
`define SRG_SEL_PHASE      4'h9
// Operation bit positions
`define SRG_RUN_ADJUST_BIT 0
`define SRG_RUN_CHANGE_BIT 3
`define SRG_RUN_READ_BIT   4
// Implemented bits of the operation group
`define SRG_RUN_USED       16'h0019
// Implemented bits of the questionable groups (eight fault flags)
`define SRG_FLT_USED       16'h00FF
// Status byte positions
`define SRG_STB_FAULT_BIT  3
`define SRG_STB_RUN_BIT    7
`define SRG_ZERO16         16'h0000
`endif

// ---- core/srg_pkg.sv ----
package srg_pkg;
   typedef logic [15:0] srg_word_t;
   typedef logic [3:0]  srg_sel_t;
endpackage : srg_pkg

// ---- core/srg_mask_if.sv ----
`timescale 1ns/1ps
interface srg_mask_if #(parameter int PHASES = 3, parameter int AW = 2);
   logic              wr_en;
   logic [AW-1:0]     wr_addr;
   logic [15:0]       wr_data;
   logic [AW-1:0]     rd_addr;
   logic [15:0]       rd_data;
   logic [PHASES-1:0] any_hit;
   logic [15:0]       ph_event [PHASES];
   modport owner (output wr_en, wr_addr, wr_data, rd_addr, ph_event,
                  input rd_data, any_hit);
   modport store (input wr_en, wr_addr, wr_data, rd_addr, ph_event,
                  output rd_data, any_hit);
endinterface : srg_mask_if

// ---- core/srg_mask_mem.sv ----
`timescale 1ns/1ps
`include "srg_cfg.svh"
module srg_mask_mem #(
   parameter int PHASES = 3,
   parameter int AW     = 2
) (
   input wire logic   mclk,
   input wire logic   resetn,
   srg_mask_if.store  mbus
);
   import srg_pkg::*;
   srg_word_t mask_r [PHASES];
   srg_word_t mask_nxt [PHASES];
   srg_word_t rd_r;
   srg_word_t rd_nxt;

   // ************************************************************
   // Per-phase enable masks, registered read port
   // ************************************************************
   always_comb begin
      rd_nxt = `SRG_ZERO16;
      for (int i = 0; i < PHASES; i++) begin
         mask_nxt[i] = mask_r[i];
         if (mbus.wr_en && (int'(mbus.wr_addr) == i)) begin
            mask_nxt[i] = mbus.wr_data & `SRG_FLT_USED; // [R11] [R16]
         end
         if (int'(mbus.rd_addr) == i) begin
            rd_nxt = mask_r[i]; // [R11]
         end
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         for (int i = 0; i < PHASES; i++) begin
            mask_r[i] <= `SRG_ZERO16; // [R16]
         end
         rd_r <= `SRG_ZERO16;
      end else begin
         mask_r <= mask_nxt;
         rd_r   <= rd_nxt;
      end
   end

   assign mbus.rd_data = rd_r;

   genvar g;
   generate
      for (g = 0; g < PHASES; g++) begin : g_hit
         assign mbus.any_hit[g] = |(mbus.ph_event[g] & mask_r[g]); // [R09]
      end
   endgenerate
endmodule : srg_mask_mem

// ---- tb/srg_status_groups_sva.sv ----
`timescale 1ns/1ps
`include "srg_cfg.svh"
module srg_status_groups_sva
   import srg_pkg::*;
#(
   parameter int PHASES = 3
) (
   input wire logic              mclk,
   input wire logic              resetn,
   input wire logic              adjust_done,
   input wire logic              output_change_complete,
   input wire logic              reading_complete,
   input wire logic [7:0]        fault_flags,
   input wire logic              cmd_valid,
   input wire logic              cmd_write,
   input wire srg_pkg::srg_sel_t cmd_sel,
   input wire logic              cmd_rvalid,
   input wire srg_pkg::srg_word_t cmd_rdata,
   input wire logic              run_summary,
   input wire logic              fault_summary,
   input wire logic              per_phase_summary,
   input wire logic [7:0]        status_byte
);
   // ****************
   // Status checks
   // ****************
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);
   a_stb_fault_bit: assert property (status_byte[3] == fault_summary)
      else $error("status byte bit 3 differs from fault summary");
   a_stb_run_bit: assert property (status_byte[7] == run_summary)
      else $error("status byte bit 7 differs from run summary");
   a_stb_unused_zero: assert property ((status_byte & 8'h77) == 8'h00)
      else $error("unused status byte bit set");
   a_phase_folds_in: assert property (per_phase_summary |-> fault_summary)
      else $error("per-phase summary not folded into fault summary");
   a_read_answer_time: assert property (cmd_rvalid |-> $past(cmd_valid && !cmd_write, 2))
      else $error("read answer without read two cycles earlier");
   a_rvalid_one_cycle: assert property (cmd_rvalid |=> !cmd_rvalid)
      else $error("read valid longer than one cycle");
   a_rdata_holds: assert property ($changed(cmd_rdata) |-> ##[0:1] cmd_rvalid)
      else $error("read data changed without answer");
   a_run_cond_live: assert property (cmd_rvalid && $past(cmd_sel, 2) == `SRG_SEL_RUN_COND
      |-> cmd_rdata == {11'h000, $past(reading_complete, 2), $past(output_change_complete, 2),
                        2'h0, $past(adjust_done, 2)})
      else $error("run condition read not live");
   a_flt_cond_live: assert property (cmd_rvalid && $past(cmd_sel, 2) == `SRG_SEL_FLT_COND
      |-> cmd_rdata == {8'h00, $past(fault_flags, 2)})
      else $error("fault condition read not live");
   a_run_unused_zero: assert property (cmd_rvalid && $past(cmd_sel, 2) <= 4'h2
      |-> (cmd_rdata & 16'hFFE6) == 16'h0000)
      else $error("unused run bit read as one");
   c_run_event_read: cover property (cmd_rvalid && $past(cmd_sel, 2) == `SRG_SEL_RUN_EVENT);
   c_run_summary: cover property (run_summary);
   c_phase_summary: cover property (per_phase_summary);
endmodule : srg_status_groups_sva

// ---- tb/srg_status_groups_tb_top.sv ----
`timescale 1ns/1ps
`include "srg_cfg.svh"
module srg_status_groups_tb_top;
   import srg_pkg::*;
   localparam int PHASES = 3;
   logic              mclk = 1'b0;
   logic              resetn = 1'b0;
   logic              adjust_done = 1'b0;
   logic              output_change_complete = 1'b0;
   logic              reading_complete = 1'b0;
   logic [7:0]        fault_flags = 8'h00;
   logic [8*PHASES-1:0] phase_fault_flags = '0;
   logic              cmd_valid = 1'b0;
   logic              cmd_write = 1'b0;
   srg_sel_t          cmd_sel = 4'h0;
   srg_word_t         cmd_wdata = 16'h0000;
   logic              cmd_rvalid;
   srg_word_t         cmd_rdata;
   logic              run_summary;
   logic              fault_summary;
   logic              per_phase_summary;
   logic [7:0]        status_byte;
   int                n_fail = 0;
   int                n_tests = 0;
   // ****************
   // Clock and device
   // ****************
   always #2 mclk = ~mclk;
   srg_status_groups #(.PHASES(PHASES), .AW(2)) u_dut (.mclk, .resetn, .adjust_done,
      .output_change_complete, .reading_complete, .fault_flags, .phase_fault_flags,
      .cmd_valid, .cmd_write, .cmd_sel, .cmd_wdata, .cmd_rvalid, .cmd_rdata, .run_summary,
      .fault_summary, .per_phase_summary, .status_byte);
   // ****************
   // Tasks
   // ****************
   task end_of_test;
      if (n_fail == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : end_of_test
   task check(input string name, input srg_word_t exp, input srg_word_t got);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask : check
   task wr(input srg_sel_t sel, input srg_word_t d);
      @(posedge mclk) #1;
      cmd_valid = 1'b1;
      cmd_write = 1'b1;
      cmd_sel = sel;
      cmd_wdata = d;
      @(posedge mclk) #1;
      cmd_valid = 1'b0;
      @(posedge mclk) #1;
   endtask : wr
   task rc(input srg_sel_t sel, input srg_word_t exp, input string name);
      srg_word_t d;
      @(posedge mclk) #1;
      cmd_valid = 1'b1;
      cmd_write = 1'b0;
      cmd_sel = sel;
      @(posedge mclk) #1;
      cmd_valid = 1'b0;
      d = 'x;
      for (int k = 0; k < 4 && cmd_rvalid !== 1'b1; k++) @(posedge mclk) #1;
      if (cmd_rvalid === 1'b1) d = cmd_rdata;
      check(name, exp, d);
   endtask : rc
   task t_reset;
      rc(`SRG_SEL_RUN_MASK, 16'h0000, "run_mask");
      rc(`SRG_SEL_FLT_MASK, 16'h0000, "flt_mask");
      rc(`SRG_SEL_PH_MASK, 16'h0000, "ph_mask");
      check("status_byte", 16'h0000, {8'h00, status_byte});
   endtask : t_reset
   task t_run;
      adjust_done = 1'b1;
      rc(`SRG_SEL_RUN_COND, 16'h0001, "run_cond");
      adjust_done = 1'b0;
      output_change_complete = 1'b1;
      reading_complete = 1'b1;
      @(posedge mclk) #1;
      output_change_complete = 1'b0;
      reading_complete = 1'b0;
      wr(`SRG_SEL_RUN_COND, 16'hFFFF);
      rc(`SRG_SEL_RUN_COND, 16'h0000, "run_cond");
      wr(`SRG_SEL_RUN_MASK, 16'h0008);
      check("status_byte", 16'h0080, {8'h00, status_byte});
      wr(`SRG_SEL_RUN_MASK, 16'hFFFF);
      rc(`SRG_SEL_RUN_MASK, 16'h0019, "run_mask");
      rc(`SRG_SEL_RUN_EVENT, 16'h0019, "run_event");
      check("status_byte", 16'h0000, {8'h00, status_byte});
      rc(`SRG_SEL_RUN_EVENT, 16'h0000, "run_event");
   endtask : t_run
   task t_fault;
      fault_flags = 8'h81;
      rc(`SRG_SEL_FLT_COND, 16'h0081, "flt_cond");
      fault_flags = 8'h00;
      wr(`SRG_SEL_FLT_MASK, 16'hFF80);
      check("status_byte", 16'h0008, {8'h00, status_byte});
      rc(`SRG_SEL_FLT_MASK, 16'h0080, "flt_mask");
      rc(`SRG_SEL_FLT_EVENT, 16'h0081, "flt_event");
      check("status_byte", 16'h0000, {8'h00, status_byte});
      rc(`SRG_SEL_FLT_EVENT, 16'h0000, "flt_event");
   endtask : t_fault
   task t_phase;
      phase_fault_flags = {8'h03, 8'h24, 8'h00};
      wr(`SRG_SEL_PHASE, 16'h0002);
      rc(`SRG_SEL_PH_COND, 16'h0003, "ph_cond");
      phase_fault_flags = '0;
      wr(`SRG_SEL_PH_MASK, 16'h0001);
      check("ph_sum", 16'h0001, {15'h0000, per_phase_summary});
      check("status_byte", 16'h0008, {8'h00, status_byte});
      wr(`SRG_SEL_PHASE, 16'h0001);
      wr(`SRG_SEL_PHASE, 16'h0003);
      wr(`SRG_SEL_PHASE, 16'h0004);
      rc(`SRG_SEL_PHASE, 16'h0001, "phase");
      rc(`SRG_SEL_PH_MASK, 16'h0000, "ph_mask");
      rc(`SRG_SEL_PH_EVENT, 16'h0024, "ph_event");
      rc(`SRG_SEL_PH_EVENT, 16'h0000, "ph_event");
      wr(`SRG_SEL_PHASE, 16'h0002);
      rc(`SRG_SEL_PH_MASK, 16'h0001, "ph_mask");
      rc(`SRG_SEL_PH_EVENT, 16'h0003, "ph_event");
      check("ph_sum", 16'h0000, {15'h0000, per_phase_summary});
      rc(4'hF, 16'h0000, "unmapped");
   endtask : t_phase
   initial begin
      repeat (3) @(posedge mclk);
      #1 resetn = 1'b1;
      t_reset();
      t_run();
      t_fault();
      t_phase();
      end_of_test();
   end
   initial begin
      #20000;
      n_fail++;
      end_of_test();
   end
endmodule : srg_status_groups_tb_top
bind srg_status_groups srg_status_groups_sva #(.PHASES(PHASES)) u_sva (.mclk, .resetn,
   .adjust_done, .output_change_complete, .reading_complete, .fault_flags, .cmd_valid,
   .cmd_write, .cmd_sel, .cmd_rvalid, .cmd_rdata, .run_summary, .fault_summary,
   .per_phase_summary, .status_byte);
